// ===== hw/block_string_move.sv
// String move engine: copies elements memory to memory under APB control
// Assumes a simple memory port that answers reads with an i_mem_ack style handshake
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "string_move_params.svh"
// Function
// RULE_01 - Copy source element to destination location
// RULE_02 - Ascending: pointers plus one or two
// RULE_03 - Descending: pointers minus one or two
// RULE_04 - Then decrement the counter register by one
// RULE_05 - Single step: overflow set when counter zero
// RULE_06 - Repeat forms loop until counter zero
// RULE_07 - Up to 65536 bytes, words at most 32768
// RULE_08 - Repeat takes eleven plus nine per element; code takes two start cycles plus at least eleven per element
// RULE_09 - Interrupt accepted after any element step; code takes it only in repeat forms with irq_en, not after the last
// RULE_10 - Save instruction start as return address
// RULE_11 - Each accepted interrupt adds seven cycles
// RULE_12 - Overlap, source lower: software uses descending
// RULE_13 - Overlap, source higher: software uses ascending
// RULE_14 - Commit pointers and counter before interrupt check
module block_string_move
    import string_move_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Instruction context
    input wire logic [15:0] i_instr_pc,
    input wire logic i_int_pending,
    output logic o_int_accept,
    // Memory port
    output logic o_mem_req,
    output logic o_mem_wr,
    output logic [15:0] o_mem_addr,
    output logic [15:0] o_mem_wdata,
    output logic o_mem_byte,
    input wire logic i_mem_ack,
    input wire logic [15:0] i_mem_rdata
);
    typedef enum logic [2:0] {
        S_IDLE, S_START, S_READ, S_WAIT, S_WRITE, S_STEP, S_INT
    } state_t;
    state_t state;
    logic [15:0] src_ptr;
    logic [15:0] dst_ptr;
    logic [15:0] counter;
    logic [15:0] ret_pc;
    logic ovf;
    logic suspended;
    logic repeat_mode;
    logic desc_mode;
    logic byte_mode;
    logic irq_en;
    logic [3:0] wait_cnt;
    logic int_sync1;
    logic int_sync2;
    logic ack_sync1;
    logic ack_sync2;
    logic [15:0] rd_sync1;
    logic [15:0] rd_sync2;
    // Element FIFO between read and write phases
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    elem_t fifo_in;
    elem_t fifo_out;
    sm_fifo #(.WIDTH($bits(elem_t)), .DEPTH(`SM_FIFO_DEPTH)) u_fifo (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out)
    );
    function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic d,
                                             input logic b);
        logic [15:0] inc;
        inc = b ? 16'h0001 : 16'h0002;
        step_ptr = d ? p - inc : p + inc; // [RULE_02] [RULE_03]
    endfunction
    // APB decode
    wire apb_wr = i_psel && i_penable && i_pwrite && o_pready;
    wire apb_rd = i_psel && !i_penable && !i_pwrite;
    wire hit_ctrl = i_paddr == `SM_REG_CTRL;
    wire hit_src = i_paddr == `SM_REG_SRC;
    wire hit_dst = i_paddr == `SM_REG_DST;
    wire hit_cnt = i_paddr == `SM_REG_CNT;
    wire hit_stat = i_paddr == `SM_REG_STAT;
    wire hit_rpc = i_paddr == `SM_REG_RPC;
    wire hit_any = hit_ctrl || hit_src || hit_dst || hit_cnt || hit_stat || hit_rpc;
    wire busy = state != S_IDLE;
    wire go = apb_wr && hit_ctrl && i_pwdata[`SM_CTRL_GO] && !busy;
    wire [15:0] next_counter = counter - 16'h0001; // [RULE_04]
    wire last_elem = next_counter == 16'h0000;
    wire take_int = repeat_mode && irq_en && int_sync2 && !last_elem; // [RULE_09]
    wire [15:0] rd_value = i_paddr == `SM_REG_SRC ? src_ptr :
                           hit_dst ? dst_ptr :
                           hit_cnt ? counter :
                           hit_rpc ? ret_pc :
                           hit_stat ? {13'h0000, suspended, ovf, busy} :
                           hit_ctrl ? {11'h000, irq_en, byte_mode, desc_mode, repeat_mode,
                                       1'b0} : 16'h0000;
    assign fifo_in_valid = state == S_WAIT && ack_sync2;
    assign fifo_in = '{addr: dst_ptr, data: rd_sync2, byte_en: byte_mode}; // [RULE_01]
    assign fifo_out_ready = state == S_WRITE && o_mem_req && o_mem_wr && ack_sync2;
    // Interrupt, memory ack and read data inputs pass two flip-flops
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            int_sync1 <= 1'b0;
            int_sync2 <= 1'b0;
            ack_sync1 <= 1'b0;
            ack_sync2 <= 1'b0;
            rd_sync1 <= 16'h0000;
            rd_sync2 <= 16'h0000;
        end else begin
            int_sync1 <= i_int_pending;
            int_sync2 <= int_sync1;
            ack_sync1 <= i_mem_ack && o_mem_req;
            ack_sync2 <= ack_sync1 && o_mem_req;
            rd_sync1 <= i_mem_rdata;
            rd_sync2 <= rd_sync1;
        end
    end
    // APB slave, answers in the access cycle
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !hit_any;
            if (apb_rd) o_prdata <= {16'h0000, rd_value};
        end
    end
    // Control registers
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            repeat_mode <= 1'b0;
            desc_mode <= 1'b0;
            byte_mode <= 1'b0;
            irq_en <= 1'b0;
        end else if (apb_wr && hit_ctrl && !busy) begin
            repeat_mode <= i_pwdata[`SM_CTRL_REP];
            desc_mode <= i_pwdata[`SM_CTRL_DESC];
            byte_mode <= i_pwdata[`SM_CTRL_BYTE];
            irq_en <= i_pwdata[`SM_CTRL_IRQ];
        end
    end
    // Engine
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= S_IDLE;
            src_ptr <= 16'h0000;
            dst_ptr <= 16'h0000;
            counter <= 16'h0000;
            ret_pc <= 16'h0000;
            ovf <= 1'b0;
            suspended <= 1'b0;
            wait_cnt <= 4'h0;
            o_int_accept <= 1'b0;
            o_mem_req <= 1'b0;
            o_mem_wr <= 1'b0;
            o_mem_addr <= 16'h0000;
            o_mem_wdata <= 16'h0000;
            o_mem_byte <= 1'b0;
        end else begin
            o_int_accept <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (apb_wr && hit_src) src_ptr <= i_pwdata[15:0];
                    if (apb_wr && hit_dst) dst_ptr <= i_pwdata[15:0];
                    if (apb_wr && hit_cnt) counter <= i_pwdata[15:0]; // [RULE_07]
                    if (go) begin
                        ret_pc <= i_instr_pc;
                        suspended <= 1'b0;
                        wait_cnt <= 4'(`SM_START_CYCLES - `SM_ELEM_CYCLES);
                        state <= S_START;
                    end
                end
                S_START: begin
                    if (wait_cnt > 4'h1) begin
                        wait_cnt <= wait_cnt - 4'h1; // [RULE_08]
                    end else begin
                        wait_cnt <= 4'h0;
                        state <= S_READ;
                    end
                end
                S_READ: begin
                    o_mem_req <= 1'b1;
                    o_mem_wr <= 1'b0;
                    o_mem_addr <= src_ptr; // [RULE_01]
                    o_mem_byte <= byte_mode;
                    state <= S_WAIT;
                end
                S_WAIT: begin
                    if (ack_sync2 && fifo_in_ready) begin
                        o_mem_req <= 1'b0;
                        state <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (!o_mem_req && fifo_out_valid) begin
                        o_mem_req <= 1'b1;
                        o_mem_wr <= 1'b1;
                        o_mem_addr <= fifo_out.addr;
                        o_mem_wdata <= fifo_out.data;
                        o_mem_byte <= fifo_out.byte_en;
                    end else if (fifo_out_ready) begin
                        o_mem_req <= 1'b0;
                        o_mem_wr <= 1'b0;
                        state <= S_STEP;
                    end
                end
                S_STEP: begin
                    // Commit state first, then decide
                    src_ptr <= step_ptr(src_ptr, desc_mode, byte_mode); // [RULE_14]
                    dst_ptr <= step_ptr(dst_ptr, desc_mode, byte_mode);
                    counter <= next_counter; // [RULE_04]
                    ovf <= last_elem; // [RULE_05] [RULE_06]
                    if (!repeat_mode || last_elem) begin
                        state <= S_IDLE;
                    end else if (take_int) begin
                        wait_cnt <= 4'(`SM_INT_CYCLES); // [RULE_11]
                        state <= S_INT;
                    end else begin
                        state <= S_READ; // [RULE_06]
                    end
                end
                S_INT: begin
                    if (wait_cnt > 4'h1) begin
                        wait_cnt <= wait_cnt - 4'h1;
                    end else begin
                        suspended <= 1'b1; // [RULE_10]
                        o_int_accept <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
    // Helper counter for checks
    logic [15:0] elems_done;
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) elems_done <= 16'h0000;
        else if (go) elems_done <= 16'h0000;
        else if (state == S_STEP) elems_done <= elems_done + 16'h0001;
    end
    AST_COUNTER_DEC: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_04]
        state == S_STEP |=> counter == $past(counter) - 16'h0001)
        else $error("counter not decremented");
    AST_PTR_ASC: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_02]
        state == S_STEP && !desc_mode |=>
        src_ptr == $past(src_ptr) + (byte_mode ? 16'h0001 : 16'h0002))
        else $error("ascending step wrong");
    AST_PTR_DESC: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_03]
        state == S_STEP && desc_mode |=>
        dst_ptr == $past(dst_ptr) - (byte_mode ? 16'h0001 : 16'h0002))
        else $error("descending step wrong");
    AST_OVF_STEP: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_05]
        state == S_STEP && !repeat_mode |=> ovf == (counter == 16'h0000))
        else $error("overflow flag wrong");
    AST_REP_END: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_06]
        state == S_STEP && repeat_mode && last_elem |=> state == S_IDLE && ovf)
        else $error("repeat did not finish at zero");
    AST_WRITE_DATA: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_01]
        $rose(o_mem_wr) |-> o_mem_wdata == fifo_out.data)
        else $error("write data not read element");
    sequence int_wait_s;
        state == S_INT [*7];
    endsequence
    AST_INT_SEVEN: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_11]
        $rose(state == S_INT) |-> int_wait_s ##1 o_int_accept)
        else $error("interrupt cost not seven");
    AST_RET_PC: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_10]
        go |=> ret_pc == $past(i_instr_pc))
        else $error("return pc not instruction start");
    AST_START_DELAY: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_08]
        go |=> state == S_START [*2] ##1 state == S_READ)
        else $error("start overhead wrong");
    AST_INT_AFTER_COMMIT: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_14]
        $rose(state == S_INT) |-> $past(state) == S_STEP && elems_done != 16'h0000)
        else $error("interrupt before commit");
    AST_IDLE_NO_REQ: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_01]
        state == S_IDLE |-> !o_mem_req)
        else $error("memory request left open while idle");
    AST_ACCEPT_STATE: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RULE_10]
        o_int_accept |-> suspended && state == S_IDLE && counter != 16'h0000)
        else $error("suspend state inconsistent at accept");
endmodule // block_string_move

// ===== hw/sm_fifo.sv
// Parameterised valid/ready FIFO
// Assumes a single clock and asynchronous active-high reset
`timescale 1ns/10ps
module sm_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;
    assign o_in_ready = cnt != (AW+1)'(DEPTH);
    assign o_out_valid = cnt != '0;
    assign o_out_data = mem[rp];
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wp] <= i_in_data;
        end
    end
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) wp <= wp + 1'b1;
            if (pop) rp <= rp + 1'b1;
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // sm_fifo

// ===== hw/string_move_params.svh
// Offsets, field positions, timing counts and FIFO depth of the string move block
// Assumes inclusion by the package, the design and the bench
`ifndef STRING_MOVE_PARAMS_SVH
`define STRING_MOVE_PARAMS_SVH
`define SM_REG_CTRL 12'h000
`define SM_REG_SRC 12'h004
`define SM_REG_DST 12'h008
`define SM_REG_CNT 12'h00C
`define SM_REG_STAT 12'h010
`define SM_REG_RPC 12'h014
`define SM_CTRL_GO 0
`define SM_CTRL_REP 1
`define SM_CTRL_DESC 2
`define SM_CTRL_BYTE 3
`define SM_CTRL_IRQ 4
`define SM_STAT_BUSY 0
`define SM_STAT_OVF 1
`define SM_STAT_SUSP 2
`define SM_START_CYCLES 11
`define SM_ELEM_CYCLES 9
`define SM_INT_CYCLES 7
`define SM_FIFO_DEPTH 16
`endif

// ===== hw/string_move_pkg.sv
// Types shared by the string move block
// Assumes the params header is on the include path
`include "string_move_params.svh"
package string_move_pkg;
    typedef enum logic [1:0] {
        MOVE_STEP_ASC,
        MOVE_STEP_DESC,
        MOVE_REP_ASC,
        MOVE_REP_DESC
    } move_kind_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic byte_en;
        logic wr;
    } mem_req_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic byte_en;
    } elem_t;
endpackage

// ===== verif/sm_mem_model.sv
// Memory partner: byte array answering the block's memory port
// Assumes the request is held until ack is seen, then dropped
`timescale 1ns/10ps
module sm_mem_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Memory port
    input wire logic i_mem_req,
    input wire logic i_mem_wr,
    input wire logic [15:0] i_mem_addr,
    input wire logic [15:0] i_mem_wdata,
    input wire logic i_mem_byte,
    output logic o_mem_ack,
    output logic [15:0] o_mem_rdata,
    // Answer delay in cycles
    input wire logic [3:0] i_latency
);
    logic [7:0] mem [0:65535];
    logic [3:0] wait_cnt;
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h3C;
        end
    end
    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_mem_ack <= 1'b0;
            o_mem_rdata <= 16'hA5A5;
            wait_cnt <= 4'h0;
        end else if (!i_mem_req) begin
            // Data line churns outside an answer
            o_mem_ack <= 1'b0;
            o_mem_rdata <= ~o_mem_rdata;
            wait_cnt <= 4'h0;
        end else if (!o_mem_ack && wait_cnt < i_latency) begin
            wait_cnt <= wait_cnt + 4'h1;
            o_mem_rdata <= ~o_mem_rdata;
        end else if (!o_mem_ack) begin
            o_mem_ack <= 1'b1;
            if (i_mem_wr) begin
                mem[i_mem_addr] <= i_mem_wdata[7:0];
                if (!i_mem_byte)
                    mem[i_mem_addr + 16'h1] <= i_mem_wdata[15:8];
            end else begin
                o_mem_rdata[7:0] <= mem[i_mem_addr];
                o_mem_rdata[15:8] <= i_mem_byte ? ~mem[i_mem_addr] : mem[i_mem_addr + 16'h1];
            end
        end
    end
endmodule // sm_mem_model

// ===== verif/tb_block_string_move.sv
// Bench for the string move block: APB tasks, all forms, interrupt, memory port
// Assumes the memory model and the design files are compiled with it
`timescale 1ns/10ps
`include "string_move_params.svh"
module tb_block_string_move;
    logic clk, rst, psel, pen, pwr, pready, pslverr, perr, intp, inta;
    logic mreq, mwr, mbyte, mack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] pc, maddr, mwdata, mrdata, k;
    logic [3:0] lat;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int n, t0;
    block_string_move i_dut (.i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_instr_pc(pc), .i_int_pending(intp),
        .o_int_accept(inta), .o_mem_req(mreq), .o_mem_wr(mwr), .o_mem_addr(maddr),
        .o_mem_wdata(mwdata), .o_mem_byte(mbyte), .i_mem_ack(mack), .i_mem_rdata(mrdata));
    sm_mem_model i_mem (.i_core_clk(clk), .i_reset(rst), .i_mem_req(mreq), .i_mem_wr(mwr),
        .i_mem_addr(maddr), .i_mem_wdata(mwdata), .i_mem_byte(mbyte), .o_mem_ack(mack),
        .o_mem_rdata(mrdata), .i_latency(lat));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int w;
        w = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (w >= 50) errors++;
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask
    task automatic wait_idle();
        int w;
        w = 0;
        do begin
            apb(1'b0, `SM_REG_STAT, 32'h0);
            w++;
        end while (rd[`SM_STAT_BUSY] !== 1'b0 && w < 500);
        if (w >= 500) errors++;
    endtask
    task automatic dchk(input logic [15:0] slo, input logic [15:0] dlo, input int len);
        for (int j = 0; j < len; j++) begin
            check("data", {24'h0, i_mem.mem[16'(dlo + j)]}, {24'h0, pat(16'(slo + j))});
        end
    endtask
    // Strings never overlap, so neither pointer order is at risk
    task automatic run_form(input logic [2:0] f, input logic [15:0] cnt, input logic [3:0] l);
        logic [15:0] s, d, m, st, ps, pd;
        s = {5'h08, f, 8'h80};
        d = {5'h04, f, 8'h80};
        lat <= l;
        apb(1'b1, `SM_REG_SRC, {16'h0, s});
        apb(1'b1, `SM_REG_DST, {16'h0, d});
        apb(1'b1, `SM_REG_CNT, {16'h0, cnt});
        apb(1'b1, `SM_REG_CTRL, {28'h0, f[0], f[1], f[2], 1'b1});
        wait_idle();
        st = f[0] ? 16'h1 : 16'h2;
        m = f[2] ? cnt : 16'h1;
        ps = f[1] ? s - m * st : s + m * st;
        pd = f[1] ? d - m * st : d + m * st;
        rchk("src", `SM_REG_SRC, {16'h0, ps});
        rchk("dst", `SM_REG_DST, {16'h0, pd});
        rchk("cnt", `SM_REG_CNT, {16'h0, cnt - m});
        rchk("ovf", `SM_REG_STAT, {30'h0, cnt == m, 1'b0});
        dchk(f[1] ? ps + st : s, f[1] ? pd + st : d, int'(m * st));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pc = 16'h1234;
        intp = 1'b0;
        lat = 4'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk("stat reset", `SM_REG_STAT, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        check("slverr", {31'h0, perr}, 32'h1);
        // Word repeat counts stay far below 32768
        for (int f = 0; f < 8; f++) begin
            run_form(3'(f), f[2] ? 16'h3 : 16'h2, 4'(f));
        end
        run_form(3'b011, 16'h1, 4'h2);
        lat <= 4'h0;
        apb(1'b1, `SM_REG_SRC, 32'h6000);
        apb(1'b1, `SM_REG_DST, 32'h7000);
        apb(1'b1, `SM_REG_CNT, 32'h4);
        t0 = cyc;
        apb(1'b1, `SM_REG_CTRL, 32'h3);
        apb(1'b1, `SM_REG_SRC, 32'h1111);
        wait_idle();
        check("cycles", {31'h0, (cyc - t0) >= 47}, 32'h1);
        rchk("src busy", `SM_REG_SRC, 32'h6008);
        lat <= 4'h2;
        apb(1'b1, `SM_REG_SRC, 32'h6000);
        apb(1'b1, `SM_REG_DST, 32'h7100);
        apb(1'b1, `SM_REG_CNT, 32'h6);
        apb(1'b1, `SM_REG_CTRL, 32'h13);
        intp <= 1'b1;
        n = 0;
        while (inta !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        intp <= 1'b0;
        check("accept", {31'h0, n < 1000}, 32'h1);
        rchk("suspended", `SM_REG_STAT, 32'h4);
        rchk("rpc", `SM_REG_RPC, 32'h1234);
        apb(1'b0, `SM_REG_CNT, 32'h0);
        k = rd[15:0];
        check("partial", {31'h0, k > 16'h0 && k < 16'h6}, 32'h1);
        rchk("src commit", `SM_REG_SRC, {16'h0, 16'h6000 + 16'h2 * (16'h6 - k)});
        apb(1'b1, `SM_REG_CTRL, 32'h13);
        wait_idle();
        rchk("cnt resume", `SM_REG_CNT, 32'h0);
        rchk("src resume", `SM_REG_SRC, 32'h600C);
        dchk(16'h6000, 16'h7100, 12);
        // Element path through the buffer, seen at the memory port
        check("mem idle", {30'h0, mreq, mwr}, 32'h0);
        check("last addr", {16'h0, maddr}, 32'h0000_710A);
        check("last data", {15'h0, mbyte, mwdata}, {16'h0, pat(16'h600B), pat(16'h600A)});
        tally_and_finish();
    end
endmodule // tb_block_string_move
